// ### hdl/tx_cfg_vector_ctrl.sv
// Transmit configuration vector control for a 10 Gb/s MAC transmitter.
// Assumes the client drives the vector on core_clk_in and flags frame
// activity with frame_start_in / frame_end_in from the datapath.
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_vec_cfg.svh"

module tx_cfg_vector_ctrl
	import tx_cfg_vec_pkg::*;
#(
	parameter bit NARROW_PATH = 1'b0
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Client configuration and requests
	input wire logic [31:0] cfg_vector_in,
	input wire logic [7:0] ifg_delay_in,
	input wire logic pause_req_in,
	// Datapath frame boundaries
	input wire logic frame_start_in,
	input wire logic frame_end_in,
	// Decoded controls
	output logic tx_reset_out,
	output logic tx_enable_out,
	output logic [14:0] max_frame_len_out,
	output logic jumbo_allow_out,
	output logic fcs_from_client_out,
	output logic fcs_append_out,
	output logic tagged_count_out,
	output logic preamble_pass_out,
	output logic pause_send_out,
	output logic [3:0] gap_mode_out,
	output logic [7:0] gap_bytes_out,
	output logic in_frame_out
);

	// ********************************
	// Local state
	// ********************************
	logic [31:0] applied_ff;
	logic [31:0] nxt_applied;
	frame_state_t state_ff;
	frame_state_t nxt_state;
	logic [14:0] dec_max_len;
	gap_mode_t dec_gap_mode;
	logic dec_dic;
	logic dec_pacing;

	// Clear reserved positions even if the client slips
	function automatic logic [31:0] mask_reserved(input logic [31:0] v);
		logic [31:0] m;
		m = v;
		m[31] = 1'b0;
		m[15] = 1'b0;
		m[13:11] = 3'b000;
		m[6] = 1'b0;
		return m;
	endfunction

	// ********************************
	// Frame boundary tracking
	// ********************************
	// A frame is open from its start strobe to its end strobe
	always_comb begin
		case (state_ff)
			ST_IDLE: begin
				if (frame_start_in && !frame_end_in) begin
					nxt_state = ST_FRAME;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			ST_FRAME: begin
				if (frame_end_in) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_FRAME;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ********************************
	// Vector capture
	// ********************************
	// Same-clock input, so no synchroniser; captured only when idle so a
	// frame never mixes settings. Reset bit passes at once: it must not wait.
	always_comb begin
		nxt_applied = applied_ff;
		if (state_ff == ST_IDLE && !frame_start_in) begin
			nxt_applied = mask_reserved(cfg_vector_in);
		end
		nxt_applied[`CFG_RESET_BIT] = cfg_vector_in[`CFG_RESET_BIT];
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			applied_ff <= `CFG_VEC_RESET;
		end else begin
			applied_ff <= nxt_applied;
		end
	end

	tx_cfg_decode #(
		.NARROW_PATH(NARROW_PATH)
	) u_decode (
		.vec_in(applied_ff),
		.max_len_out(dec_max_len),
		.gap_mode_out(dec_gap_mode),
		.dic_active_out(dec_dic),
		.pacing_active_out(dec_pacing)
	);

	// ********************************
	// Registered controls
	// ********************************
	// Reset and enable
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			tx_reset_out <= 1'b1;
			tx_enable_out <= 1'b0;
		end else begin
			tx_reset_out <= applied_ff[`CFG_RESET_BIT];
			tx_enable_out <= applied_ff[`CFG_ENABLE_BIT] &&
				!applied_ff[`CFG_RESET_BIT];
		end
	end

	// Frame format controls
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			max_frame_len_out <= `LEN_STD_MAX;
			jumbo_allow_out <= 1'b0;
			fcs_from_client_out <= 1'b0;
			fcs_append_out <= 1'b1;
			tagged_count_out <= 1'b0;
			preamble_pass_out <= 1'b0;
		end else begin
			max_frame_len_out <= dec_max_len;
			jumbo_allow_out <= applied_ff[`CFG_JUMBO_BIT];
			fcs_from_client_out <= applied_ff[`CFG_CHECKSUM_BIT];
			fcs_append_out <= !applied_ff[`CFG_CHECKSUM_BIT];
			tagged_count_out <= applied_ff[`CFG_TAGGED_BIT];
			preamble_pass_out <= applied_ff[`CFG_PREAMBLE_BIT];
		end
	end

	// Gap sizing; adjust mode never goes below the minimum gap
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			gap_mode_out <= GAP_ALIGN;
			gap_bytes_out <= `GAP_MIN_BYTES;
		end else begin
			gap_mode_out <= dec_gap_mode;
			if (dec_gap_mode == GAP_ADJUST && ifg_delay_in > `GAP_MIN_BYTES) begin
				gap_bytes_out <= ifg_delay_in;
			end else begin
				gap_bytes_out <= `GAP_MIN_BYTES;
			end
		end
	end

	// Pause requests pass only when pause generation is on and running
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pause_send_out <= 1'b0;
		end else begin
			pause_send_out <= pause_req_in && applied_ff[`CFG_PAUSE_BIT] &&
				applied_ff[`CFG_ENABLE_BIT] && !applied_ff[`CFG_RESET_BIT];
		end
	end

	// Frame activity flag
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			in_frame_out <= 1'b0;
		end else begin
			in_frame_out <= (nxt_state == ST_FRAME);
		end
	end

endmodule
`default_nettype wire

// ### hdl/tx_cfg_vec_cfg.svh
// Constants for the transmit configuration vector decoder.
// Assumes inclusion by both design files; definitions only.
`ifndef TX_CFG_VEC_CFG_SVH
`define TX_CFG_VEC_CFG_SVH

// Field positions inside the 32-bit vector
`define CFG_MAXLEN_HI 30
`define CFG_MAXLEN_LO 16
`define CFG_LEN_OVR_BIT 14
`define CFG_DIC_BIT 10
`define CFG_PACING_BIT 9
`define CFG_GAP_ADJ_BIT 8
`define CFG_PREAMBLE_BIT 7
`define CFG_PAUSE_BIT 5
`define CFG_JUMBO_BIT 4
`define CFG_CHECKSUM_BIT 3
`define CFG_TAGGED_BIT 2
`define CFG_ENABLE_BIT 1
`define CFG_RESET_BIT 0

// Reset value of the applied vector: transmitter held in reset
`define CFG_VEC_RESET 32'h0000_0001

// Frame length limits in bytes
`define LEN_STD_MAX 15'h05EE
`define LEN_TAGGED_MAX 15'h05F2
`define LEN_JUMBO_MAX 15'h7FFF

// Minimum inter-frame gap in bytes
`define GAP_MIN_BYTES 8'h0C

`endif

// ### hdl/tx_cfg_vec_pkg.sv
// Types for the transmit configuration vector decoder.
// Assumes no other package.
`default_nettype none
package tx_cfg_vec_pkg;

	// Gap policy applied between frames
	typedef enum logic [3:0] {
		GAP_ALIGN = 4'b0001,
		GAP_DEFICIT = 4'b0010,
		GAP_ADJUST = 4'b0100,
		GAP_PACED = 4'b1000
	} gap_mode_t;

	// Frame-boundary tracker states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FRAME = 2'b10
	} frame_state_t;

endpackage
`default_nettype wire

// ### hdl/tx_cfg_decode.sv
// Combinational decode of one applied configuration vector.
// Assumes the vector is already stable in the transmit clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_vec_cfg.svh"

module tx_cfg_decode
	import tx_cfg_vec_pkg::*;
#(
	parameter bit NARROW_PATH = 1'b0
) (
	// Applied vector
	input wire logic [31:0] vec_in,
	// Decoded controls
	output logic [14:0] max_len_out,
	output gap_mode_t gap_mode_out,
	output logic dic_active_out,
	output logic pacing_active_out
);

	logic lan_mode;
	logic gap_adj_used;

	// Pacing is unsupported on the narrow datapath
	assign pacing_active_out = vec_in[`CFG_PACING_BIT] && !NARROW_PATH;
	assign lan_mode = !pacing_active_out;
	// Gap adjust only counts in LAN operation
	assign gap_adj_used = vec_in[`CFG_GAP_ADJ_BIT] && lan_mode;
	// Deficit idle forced off in the two conflicting settings
	assign dic_active_out = vec_in[`CFG_DIC_BIT] && !gap_adj_used &&
		!(lan_mode && vec_in[`CFG_CHECKSUM_BIT]);

	// Gap policy priority: pacing, adjust, deficit, alignment
	always_comb begin
		if (pacing_active_out) begin
			gap_mode_out = GAP_PACED;
		end else if (gap_adj_used) begin
			gap_mode_out = GAP_ADJUST;
		end else if (dic_active_out) begin
			gap_mode_out = GAP_DEFICIT;
		end else begin
			gap_mode_out = GAP_ALIGN;
		end
	end

	// Largest permitted frame
	always_comb begin
		if (vec_in[`CFG_LEN_OVR_BIT]) begin
			max_len_out = vec_in[`CFG_MAXLEN_HI:`CFG_MAXLEN_LO];
		end else if (vec_in[`CFG_JUMBO_BIT]) begin
			max_len_out = `LEN_JUMBO_MAX;
		end else if (vec_in[`CFG_TAGGED_BIT]) begin
			max_len_out = `LEN_TAGGED_MAX;
		end else begin
			max_len_out = `LEN_STD_MAX;
		end
	end

endmodule
`default_nettype wire

// ### bench/tx_cfg_vector_ctrl_assertions.sv
// Checker for the transmit configuration vector control.
// Assumes outputs follow the input vector two edges later.
`timescale 1ns/100ps
`default_nettype none
`include "tx_cfg_vec_cfg.svh"
// ****
// Checker
// ****
module tx_cfg_vector_ctrl_assertions #(
	parameter bit NARROW_PATH = 1'b0
) (
	// Watched ports
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [31:0] cfg_vector_in,
	input wire logic pause_req_in,
	input wire logic frame_start_in,
	input wire logic in_frame_out,
	input wire logic tx_reset_out,
	input wire logic tx_enable_out,
	input wire logic [14:0] max_frame_len_out,
	input wire logic fcs_append_out,
	input wire logic pause_send_out,
	input wire logic [3:0] gap_mode_out,
	input wire logic [7:0] gap_bytes_out
);
	logic [31:0] v1_ff, v_ff;
	logic [1:0] ok_ff;
	logic p_ff;
	wire g = ok_ff[1];
	// Narrow datapath build never paces, so the LAN gap policy applies
	wire lan_ok = !v_ff[9] || NARROW_PATH;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Line the vector up with outputs; gate off frames and reset, where capture is held
	always_ff @(posedge core_clk_in) begin
		v1_ff <= cfg_vector_in;
		v_ff <= v1_ff;
		p_ff <= pause_req_in; // Pause request is registered once, one register stage fewer than the vector
		ok_ff <= {ok_ff[0] & !sys_rst_in, !sys_rst_in & !in_frame_out & !frame_start_in};
	end
	AST_ENABLE: assert property (g |-> tx_enable_out == (v_ff[1] & !v_ff[0]))
		else $error("bad enable");
	AST_RESET: assert property (g |-> tx_reset_out == v_ff[0])
		else $error("bad reset");
	AST_OVERRIDE: assert property (g && v_ff[14] |-> max_frame_len_out == v_ff[30:16])
		else $error("bad override");
	AST_DEF_LEN: assert property (g && !v_ff[14] && !v_ff[4] |->
		max_frame_len_out == (v_ff[2] ? `LEN_TAGGED_MAX : `LEN_STD_MAX)) else $error("bad limit");
	AST_FCS: assert property (g |-> fcs_append_out != v_ff[3])
		else $error("bad fcs");
	AST_PAUSE: assert property (g |-> pause_send_out == (p_ff & v_ff[5] & v_ff[1] & !v_ff[0]))
		else $error("bad pause");
	AST_LAN_GAP: assert property (g && lan_ok |->
		gap_mode_out == (v_ff[8] ? 4'h4 : (v_ff[10] & !v_ff[3]) ? 4'h2 : 4'h1))
		else $error("bad gap mode");
	AST_PACED: assert property (g && !lan_ok |-> gap_mode_out == 4'h8 &&
		gap_bytes_out == `GAP_MIN_BYTES) else $error("bad pacing");
	// Main scenarios
	CV_OVR: cover property (g && v_ff[14]);
	CV_PAUSE: cover property (pause_send_out);
	CV_FRAME: cover property (in_frame_out);
endmodule
bind tx_cfg_vector_ctrl tx_cfg_vector_ctrl_assertions #(.NARROW_PATH(NARROW_PATH)) u_chk (.*);
`default_nettype wire

// ### bench/client_model.sv
// Client model driving the configuration vector and frame strobes.
// Assumes the testbench calls its tasks; drives follow core_clk_in.
`timescale 1ns/100ps
`default_nettype none
// ****
// Client model
// ****
module client_model (
	// Clock
	input wire logic core_clk_in,
	// Toward the block
	output logic [31:0] cfg_out,
	output logic [7:0] ifg_out,
	output logic pause_out,
	output logic start_out,
	output logic end_out
);
	initial begin
		{cfg_out, ifg_out, pause_out, start_out, end_out} = '0;
	end
	// Reserved bits cleared here, so no test can leak them; no priority flow control
	task automatic drive(input logic [31:0] v, input logic p);
		@(posedge core_clk_in);
		cfg_out <= v & 32'h7FFF_47BF;
		ifg_out <= 8'h20;
		pause_out <= p;
	endtask
	// One-cycle frame start or end strobe
	task automatic strobe(input logic s);
		@(posedge core_clk_in);
		start_out <= s;
		end_out <= !s;
		@(posedge core_clk_in);
		{start_out, end_out} <= 2'h0;
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench for the transmit configuration vector control.
// Assumes the client model and the bound checker beside the block.
`timescale 1ns/100ps
`default_nettype none
// ****
// Testbench
// ****
module testbench;
	logic core_clk_in, sys_rst_in, pause_req_in, frame_start_in, frame_end_in;
	logic [31:0] cfg_vector_in;
	logic [7:0] ifg_delay_in, gap_bytes_out;
	logic tx_reset_out, tx_enable_out, jumbo_allow_out, fcs_from_client_out, fcs_append_out;
	logic tagged_count_out, preamble_pass_out, pause_send_out, in_frame_out;
	logic [14:0] max_frame_len_out;
	logic [3:0] gap_mode_out;
	logic [3:0] narrow_gap_mode;
	int num_errors = 0;
	int total_checks = 0;
	// Vectors with expected limit and gap policy
	logic [31:0] tv [10] = '{32'h0000_0002, 32'h0000_0001, 32'h0123_4002, 32'h0123_0406,
		32'h0000_040A, 32'h0000_0502, 32'h0000_0302, 32'h0000_0012, 32'h0000_0022,
		32'h0000_0082};
	logic [14:0] tm [10] = '{15'h05EE, 15'h05EE, 15'h0123, 15'h05F2, 15'h05EE,
		15'h05EE, 15'h05EE, 15'h7FFF, 15'h05EE, 15'h05EE};
	logic [3:0] tg [10] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h4, 4'h8, 4'h1, 4'h1, 4'h1};
	tx_cfg_vector_ctrl u_tx_cfg_vector_ctrl (.*);
	// Narrow datapath build: its gap policy and gap bytes differ; only the gap policy is watched
	tx_cfg_vector_ctrl #(.NARROW_PATH(1'b1)) u_tx_cfg_vector_ctrl_narrow (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .cfg_vector_in(cfg_vector_in),
		.ifg_delay_in(ifg_delay_in), .pause_req_in(pause_req_in),
		.frame_start_in(frame_start_in), .frame_end_in(frame_end_in),
		.tx_reset_out(), .tx_enable_out(), .max_frame_len_out(), .jumbo_allow_out(),
		.fcs_from_client_out(), .fcs_append_out(), .tagged_count_out(),
		.preamble_pass_out(), .pause_send_out(), .gap_mode_out(narrow_gap_mode),
		.gap_bytes_out(), .in_frame_out());
	client_model u_client_model (.core_clk_in(core_clk_in), .cfg_out(cfg_vector_in),
		.ifg_out(ifg_delay_in), .pause_out(pause_req_in), .start_out(frame_start_in),
		.end_out(frame_end_in));
	task automatic chk(input logic [14:0] a, input logic [14:0] e);
		total_checks++;
		if (a !== e) begin
			num_errors++;
			$display("MISMATCH %0t got %h want %h", $time, a, e);
		end
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	// Three edges per setting: output lands two edges after the drive
	initial begin
		sys_rst_in = 1'b1;
		repeat (5) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		// Outputs still show the reset values launched by the last reset edge
		#1;
		chk(15'(tx_reset_out), 15'h1);
		chk(max_frame_len_out, 15'h05EE);
		chk(15'(gap_mode_out), 15'h1);
		for (int i = 0; i < 10; i++) begin
			u_client_model.drive(tv[i], 1'b1);
			repeat (3) @(posedge core_clk_in);
			#1;
			chk(max_frame_len_out, tm[i]);
			chk(15'(gap_mode_out), 15'(tg[i]));
			chk(15'(narrow_gap_mode), (tg[i] == 4'h8) ? 15'h4 : 15'(tg[i]));
			chk(15'(jumbo_allow_out), 15'(tv[i][4]));
			chk(15'(fcs_from_client_out), 15'(tv[i][3]));
			chk(15'(tagged_count_out), 15'(tv[i][2]));
			chk(15'(preamble_pass_out), 15'(tv[i][7]));
			chk(15'(gap_bytes_out), (tv[i][8] && !tv[i][9]) ? 15'h20 : 15'h0C);
			chk(15'(tx_enable_out), 15'(tv[i][1] & !tv[i][0]));
			chk(15'(tx_reset_out), 15'(tv[i][0]));
			chk(15'(fcs_append_out), 15'(!tv[i][3]));
			chk(15'(pause_send_out), 15'(tv[i][5] & tv[i][1] & !tv[i][0]));
		end
		// A change inside a frame must wait for the frame end
		u_client_model.drive(32'h0000_0002, 1'b0);
		u_client_model.strobe(1'b1);
		u_client_model.drive(32'h0000_0000, 1'b0);
		repeat (4) @(posedge core_clk_in);
		#1;
		chk(15'(tx_enable_out), 15'h1);
		chk(15'(in_frame_out), 15'h1);
		u_client_model.strobe(1'b0);
		repeat (4) @(posedge core_clk_in);
		#1;
		chk(15'(tx_enable_out), 15'h0);
		chk(15'(in_frame_out), 15'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
